// ### design/mrs_ctrl.sv
// Controller end: decodes write frames, gates start/stop behind unlock
`timescale 1ns/10ps
`default_nettype none
module mrs_ctrl (
  input  wire logic    clk,
  input  wire logic    rst_n,
  mrs_link_if.ctrl     link,
  input  wire logic    momentary_mode,
  input  wire logic [7:0] fault_code,
  output logic         engine_start,
  output logic         engine_stop,
  output logic         cmd_rejected,
  output logic         crc_error,
  output logic [15:0]  unlock_value,
  output logic [7:0]   status_code
);

  logic [2:0]   idx_q, idx_d;
  logic [7:0]   buf_q [0:5];
  logic [7:0]   buf_d [0:5];
  logic [15:0]  crc_q, crc_d;
  logic [7:0]   crc_lo_q, crc_lo_d;
  logic [15:0]  unl_q, unl_d;
  logic         armed_q, armed_d;
  logic         start_q, start_d;
  logic         stop_q, stop_d;
  logic         rej_q, rej_d;
  logic         crce_q, crce_d;
  logic [7:0]   stat_q, stat_d;
  logic [15:0]  radr;
  logic [15:0]  val;
  logic         frame_ok;

  assign link.ready   = 1'b1;
  assign engine_start = start_q;
  assign engine_stop  = stop_q;
  assign cmd_rejected = rej_q;
  assign crc_error    = crce_q;
  assign unlock_value = unl_q;
  assign status_code  = stat_q;

  // ==========================================================
  // Receive and execute
  always_comb
  begin
    idx_d    = idx_q;
    buf_d    = buf_q;
    crc_d    = crc_q;
    crc_lo_d = crc_lo_q;
    unl_d    = unl_q;
    armed_d  = armed_q;
    start_d  = 1'b0;
    stop_d   = 1'b0;
    rej_d    = 1'b0;
    crce_d   = 1'b0;
    radr     = {buf_q[2], buf_q[3]};
    val      = {buf_q[4], link.data};
    frame_ok = 1'b0;
    // Codes 0 to 4 pass through; other faults also reported as read
    stat_d   = fault_code;
    if (link.valid)
    begin
      idx_d = idx_q + 3'd1;
      if (idx_q < 3'd6)
      begin
        buf_d[idx_q] = link.data;
        crc_d        = mrs_pkg::crc_byte(crc_q, link.data);
      end
      else if (idx_q == 3'd6)
      begin
        crc_lo_d = link.data;
      end
      else
      begin
        crc_d    = mrs_pkg::CRC_INIT;
        frame_ok = ({link.data, crc_lo_q} == crc_q)
                   && buf_q[0] == mrs_pkg::SLAVE_ADDR
                   && buf_q[1] == mrs_pkg::FUNC_WRITE_ONE;
        crce_d   = ({link.data, crc_lo_q} != crc_q);
        radr     = {buf_q[2], buf_q[3]};
        val      = {buf_q[4], buf_q[5]};
        if (frame_ok && radr == mrs_pkg::REG_UNLOCK)
        begin
          if (val != unl_q)
          begin
            armed_d = 1'b1;
          end
          unl_d = val;
        end
        else if (frame_ok && radr == mrs_pkg::REG_COMMAND)
        begin
          if (armed_q && momentary_mode
              && (val == mrs_pkg::CMD_START || val == mrs_pkg::CMD_STOP))
          begin
            start_d = (val == mrs_pkg::CMD_START);
            stop_d  = (val == mrs_pkg::CMD_STOP);
            armed_d = 1'b0;
          end
          else
          begin
            rej_d = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q    <= 3'd0;
      for (int i = 0; i < 6; i++)
      begin
        buf_q[i] <= 8'h00;
      end
      crc_q    <= mrs_pkg::CRC_INIT;
      crc_lo_q <= 8'h00;
      unl_q    <= mrs_pkg::UNLOCK_RESET;
      armed_q  <= 1'b0;
      start_q  <= 1'b0;
      stop_q   <= 1'b0;
      rej_q    <= 1'b0;
      crce_q   <= 1'b0;
      stat_q   <= mrs_pkg::STAT_NORMAL;
    end
    else
    begin
      idx_q    <= idx_d;
      buf_q    <= buf_d;
      crc_q    <= crc_d;
      crc_lo_q <= crc_lo_d;
      unl_q    <= unl_d;
      armed_q  <= armed_d;
      start_q  <= start_d;
      stop_q   <= stop_d;
      rej_q    <= rej_d;
      crce_q   <= crce_d;
      stat_q   <= stat_d;
    end
  end

endmodule : mrs_ctrl
`default_nettype wire

// ### design/mrs_link_if.sv
// Byte link carrying Modbus frames between master and controller
`timescale 1ns/10ps
`default_nettype none
interface mrs_link_if;
  logic       valid;
  logic [7:0] data;
  logic       ready;
  modport master (output valid, output data, input ready);
  modport ctrl   (input valid, input data, output ready);
endinterface : mrs_link_if
`default_nettype wire

// ### design/mrs_master.sv
// Master end: builds unlock and command frames with CRC
`timescale 1ns/10ps
`default_nettype none
module mrs_master #(
  parameter int GAP = mrs_pkg::GAP_CYCLES
) (
  input  wire logic    clk,
  input  wire logic    rst_n,
  mrs_link_if.master   link,
  input  wire logic    start_req,
  input  wire logic    stop_req,
  output logic         busy,
  output logic [15:0]  unlock_count
);

  typedef enum logic [1:0]
  {
    M_IDLE = 2'b00,
    M_SEND = 2'b01,
    M_WAIT = 2'b10
  } mrs_mstate_type;

  mrs_mstate_type   st_q, st_d;
  logic [15:0]      cnt_q, cnt_d;
  logic [15:0]      code_q, code_d;
  logic             second_q, second_d;
  logic [2:0]       idx_q, idx_d;
  logic [15:0]      crc_q, crc_d;
  logic [31:0]      tmr_q, tmr_d;
  logic [15:0]      radr;
  logic [15:0]      val;
  logic [7:0]       byte_out;

  // ==========================================================
  // Frame byte selection
  always_comb
  begin
    radr = second_q ? mrs_pkg::REG_COMMAND : mrs_pkg::REG_UNLOCK;
    val  = second_q ? code_q : cnt_q;
    unique case (idx_q)
      3'd0: byte_out = mrs_pkg::SLAVE_ADDR;
      3'd1: byte_out = mrs_pkg::FUNC_WRITE_ONE;
      3'd2: byte_out = radr[15:8];
      3'd3: byte_out = radr[7:0];
      3'd4: byte_out = val[15:8];
      3'd5: byte_out = val[7:0];
      3'd6: byte_out = crc_q[7:0];
      3'd7: byte_out = crc_q[15:8];
    endcase
  end

  assign link.valid   = (st_q == M_SEND);
  assign link.data    = byte_out;
  assign busy         = (st_q != M_IDLE);
  assign unlock_count = cnt_q;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    code_d   = code_q;
    second_d = second_q;
    idx_d    = idx_q;
    crc_d    = crc_q;
    tmr_d    = tmr_q;
    unique case (st_q)
      M_IDLE:
      begin
        if (start_req || stop_req)
        begin
          cnt_d    = cnt_q + 16'h0001;
          code_d   = start_req ? mrs_pkg::CMD_START : mrs_pkg::CMD_STOP;
          second_d = 1'b0;
          idx_d    = 3'd0;
          crc_d    = mrs_pkg::CRC_INIT;
          st_d     = M_SEND;
        end
      end
      M_SEND:
      begin
        if (link.ready)
        begin
          if (idx_q < 3'd6)
          begin
            crc_d = mrs_pkg::crc_byte(crc_q, byte_out);
          end
          idx_d = idx_q + 3'd1;
          if (idx_q == 3'd7)
          begin
            if (second_q)
            begin
              st_d = M_IDLE;
            end
            else
            begin
              tmr_d = 32'h0000_0000;
              st_d  = M_WAIT;
            end
          end
        end
      end
      M_WAIT:
      begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (tmr_q >= 32'(GAP - 1))
        begin
          second_d = 1'b1;
          idx_d    = 3'd0;
          crc_d    = mrs_pkg::CRC_INIT;
          st_d     = M_SEND;
        end
      end
      default: st_d = M_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q     <= M_IDLE;
      cnt_q    <= mrs_pkg::UNLOCK_RESET;
      code_q   <= 16'h0000;
      second_q <= 1'b0;
      idx_q    <= 3'd0;
      crc_q    <= mrs_pkg::CRC_INIT;
      tmr_q    <= 32'h0000_0000;
    end
    else
    begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      code_q   <= code_d;
      second_q <= second_d;
      idx_q    <= idx_d;
      crc_q    <= crc_d;
      tmr_q    <= tmr_d;
    end
  end

endmodule : mrs_master
`default_nettype wire

// ### design/mrs_pkg.sv
// Constants shared by the remote start/stop controller end and master end
// Operation
// - Command refused unless unlock register newly written
// - Master writes fresh unlock value before command
// - Code 0xAA starts, 0x55 stops engine
// - Master waits for controller response before command (master here sends after a fixed GAP, no response read)
// - One second gap between unlock and command
// - Commands act only with momentary start type
// - Frame: address, function 6, register, value
// - CRC appended low byte first
// - Both writes go to slave address 10
// - Sixteen-bit unlock counter increments, wraps at 65535
// - Unlock register 22, command register 19
// - Status codes: 0 normal through 4 flow
`default_nettype none
package mrs_pkg;

  // ==========================================================
  // Frame and register map
  localparam logic [7:0]  SLAVE_ADDR      = 8'h0A;
  localparam logic [7:0]  FUNC_WRITE_ONE  = 8'h06;
  localparam logic [15:0] REG_COMMAND     = 16'h0013;
  localparam logic [15:0] REG_UNLOCK      = 16'h0016;
  localparam logic [15:0] CMD_START       = 16'h00AA;
  localparam logic [15:0] CMD_STOP        = 16'h0055;
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;
  localparam logic [15:0] CRC_POLY        = 16'hA001;
  localparam logic [15:0] UNLOCK_RESET    = 16'h0000;
  localparam int          FRAME_BYTES     = 8;

  // ==========================================================
  // Status codes
  localparam logic [7:0]  STAT_NORMAL     = 8'h00;
  localparam logic [7:0]  STAT_LOW_OIL    = 8'h01;
  localparam logic [7:0]  STAT_HIGH_TEMP  = 8'h02;
  localparam logic [7:0]  STAT_AUX3       = 8'h03;
  localparam logic [7:0]  STAT_FLOW_LOSS  = 8'h04;

  // ==========================================================
  // Timing
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          GAP_MS          = 1000;
  localparam int          GAP_CYCLES      = CLK_HZ / 1000 * GAP_MS;

  // One byte step of CRC-16
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

endpackage : mrs_pkg
`default_nettype wire

// ### test/mrs_check_pkg.sv
// Reference frame builder and CRC for the link checks
`default_nettype none
package mrs_check_pkg;

  function automatic logic [15:0] crc6(input logic [47:0] m);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < 48; i++)
    begin
      if (i % 8 == 0) c = c ^ {8'h00, m[47 - i -: 8]};
      c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc6

  function automatic logic [63:0] frm(input logic [15:0] r, input logic [15:0] v);
    logic [15:0] c;
    c = crc6({8'h0A, 8'h06, r, v});
    return {8'h0A, 8'h06, r, v, c[7:0], c[15:8]};
  endfunction : frm

endpackage : mrs_check_pkg
`default_nettype wire

// ### test/mrs_monitor.sv
// Concurrent checks on the master-to-controller byte link
`timescale 1ns/10ps
`default_nettype none
module mrs_monitor #(
  parameter int GAP = 20
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       valid,
  input wire logic [7:0] data
);
  logic [2:0]  idx_q;
  logic [55:0] sh_q;
  logic [31:0] idle_q;
  logic        unl_q;
  logic [15:0] last_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Byte position, byte history and idle time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q  <= 3'h0;
      sh_q   <= '0;
      idle_q <= '0;
      unl_q  <= 1'b0;
      last_q <= 16'h0000;
    end
    else if (valid)
    begin
      idx_q  <= idx_q + 3'h1;
      sh_q   <= {sh_q[47:0], data};
      idle_q <= '0;
      if (idx_q == 3'h3) unl_q <= (data == 8'h16);
      if (idx_q == 3'h5 && unl_q) last_q <= {sh_q[7:0], data};
    end
    else if (idle_q < GAP) idle_q <= idle_q + 32'h0000_0001;
  end

  // ==========================================================
  // Frame checks
  a_slave_addr: assert property (valid && idx_q == 3'h0 |-> data == 8'h0A)
    else $error("wrong slave address");
  a_func_code: assert property (valid && idx_q == 3'h1 |-> data == 8'h06)
    else $error("wrong function code");
  a_reg_addr: assert property (valid && idx_q == 3'h3 |->
    sh_q[7:0] == 8'h00 && (data == 8'h16 || data == 8'h13))
    else $error("wrong register address");
  a_frame_burst: assert property ($rose(valid) |-> valid [*8] ##1 !valid)
    else $error("frame not eight bytes");
  a_unlock_gap: assert property ($rose(valid) && unl_q |-> idle_q >= GAP)
    else $error("command sent too soon");
  a_crc_order: assert property (valid && idx_q == 3'h7 |->
    {data, sh_q[7:0]} == mrs_check_pkg::crc6(sh_q[55:8]))
    else $error("bad frame check");
  a_unlock_step: assert property (valid && idx_q == 3'h5 && unl_q |->
    {sh_q[7:0], data} == last_q + 16'h0001)
    else $error("unlock value not stepped");
  a_cmd_code: assert property (valid && idx_q == 3'h5 && !unl_q |->
    {sh_q[7:0], data} == 16'h00AA || {sh_q[7:0], data} == 16'h0055)
    else $error("unknown command code");
endmodule : mrs_monitor
`default_nettype wire

// ### test/tb.sv
// Self-checking bench: master and controller back to back, plus a faulty sender
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk, rst_n, start_req, stop_req, mom, busy;
  logic        es, ep, rj, ce, fs, fp, frj, fce;
  logic [7:0]  fault, sc;
  logic [15:0] cnt, uv, fuv, exp_cnt;
  int          failures, total_checks;

  mrs_link_if link_a ();
  mrs_link_if link_b ();
  mrs_master #(.GAP(20)) mrs_master_i (.clk(clk), .rst_n(rst_n), .link(link_a),
    .start_req(start_req), .stop_req(stop_req), .busy(busy), .unlock_count(cnt));
  mrs_ctrl mrs_ctrl_i (.clk(clk), .rst_n(rst_n), .link(link_a), .momentary_mode(mom),
    .fault_code(fault), .engine_start(es), .engine_stop(ep), .cmd_rejected(rj),
    .crc_error(ce), .unlock_value(uv), .status_code(sc));
  mrs_ctrl mrs_ctrl_f_i (.clk(clk), .rst_n(rst_n), .link(link_b), .momentary_mode(1'b1),
    .fault_code(8'h00), .engine_start(fs), .engine_stop(fp), .cmd_rejected(frj),
    .crc_error(fce), .unlock_value(fuv), .status_code());
  mrs_monitor #(.GAP(20)) mrs_monitor_i (.clk(clk), .rst_n(rst_n),
    .valid(link_a.valid), .data(link_a.data));

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Master request, capture both frames, judge the controller's answer
  task automatic run_cmd(input logic stp, input logic m);
    logic [127:0] got;
    int n;
    int k;
    logic [15:0] code;
    code = stp ? 16'h0055 : 16'h00AA;
    exp_cnt = exp_cnt + 16'h0001;
    @(posedge clk) #1 {start_req, stop_req, mom} = {!stp, stp, m};
    @(posedge clk) #1 {start_req, stop_req} = 2'b00;
    chk("busy", busy, 64'h1);
    n = 0;
    k = 0;
    while (n < 16 && k < 200)
    begin
      @(negedge clk);
      k++;
      if (link_a.valid)
      begin
        got = {got[119:0], link_a.data};
        n++;
      end
    end
    @(negedge clk);
    chk("unlock_frame", got[127:64], mrs_check_pkg::frm(16'h0016, exp_cnt));
    chk("command_frame", got[63:0], mrs_check_pkg::frm(16'h0013, code));
    chk("engine_start", es, m & !stp);
    chk("engine_stop", ep, m & stp);
    chk("rejected", {rj, ce}, {!m, 1'b0});
    chk("busy_end", busy, 64'h0);
    chk("unlock_value", {uv, cnt}, {exp_cnt, exp_cnt});
  endtask : run_cmd

  // Faulty sender on the second link; exp is start, stop, reject, crc error
  task automatic send_b(input logic [15:0] r, input logic [15:0] v, input logic bad,
                        input logic [3:0] exp);
    drive_b(mrs_check_pkg::frm(r, v) ^ {63'h0, bad}, exp);
  endtask : send_b

  // Raw frame on the second link, pulses judged just after its last byte
  task automatic drive_b(input logic [63:0] f, input logic [3:0] exp);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk) #1 link_b.valid = 1'b1;
      link_b.data = f[63 - 8 * i -: 8];
    end
    @(posedge clk) #1 link_b.valid = 1'b0;
    link_b.data = ~link_b.data;
    chk("fault_link", {fs, fp, frj, fce}, exp);
  endtask : drive_b

  // Frames for another slave or another function change nothing
  task automatic t_addr;
    logic [15:0] c;
    c = mrs_check_pkg::crc6({8'h0B, 8'h06, 16'h0016, 16'h0009});
    drive_b({8'h0B, 8'h06, 16'h0016, 16'h0009, c[7:0], c[15:8]}, 4'b0000);
    c = mrs_check_pkg::crc6({8'h0A, 8'h03, 16'h0016, 16'h0009});
    drive_b({8'h0A, 8'h03, 16'h0016, 16'h0009, c[7:0], c[15:8]}, 4'b0000);
    chk("foreign_unlock", fuv, 16'h0008);
    send_b(16'h0013, 16'h0055, 1'b0, 4'b0010);
    $display("done t_addr");
  endtask : t_addr

  // Reset in the middle of an unlock frame, then a full command again
  task automatic t_reset;
    @(posedge clk) #1 start_req = 1'b1;
    @(posedge clk) #1 start_req = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b0;
    @(posedge clk) #1 chk("reset_state", {busy, link_a.valid, cnt, uv}, 34'h0);
    rst_n = 1'b1;
    exp_cnt = 16'h0000;
    run_cmd(1'b0, 1'b1);
    $display("done t_reset");
  endtask : t_reset

  task automatic t_master;
    run_cmd(1'b0, 1'b1);
    run_cmd(1'b1, 1'b1);
    run_cmd(1'b0, 1'b0);
    run_cmd(1'b1, 1'b1);
    $display("done t_master");
  endtask : t_master

  task automatic t_lock;
    send_b(16'h0013, 16'h00AA, 1'b0, 4'b0010);
    send_b(16'h0016, 16'h0005, 1'b0, 4'b0000);
    send_b(16'h0013, 16'h00AA, 1'b0, 4'b1000);
    send_b(16'h0013, 16'h0055, 1'b0, 4'b0010);
    send_b(16'h0016, 16'h0005, 1'b0, 4'b0000);
    send_b(16'h0013, 16'h0055, 1'b0, 4'b0010);
    send_b(16'h0016, 16'h0006, 1'b1, 4'b0001);
    send_b(16'h0013, 16'h0055, 1'b0, 4'b0010);
    send_b(16'h0016, 16'h0007, 1'b0, 4'b0000);
    send_b(16'h0013, 16'h0012, 1'b0, 4'b0010);
    send_b(16'h0016, 16'h0008, 1'b0, 4'b0000);
    send_b(16'h0013, 16'h0055, 1'b0, 4'b0100);
    chk("fault_unlock", fuv, 16'h0008);
    $display("done t_lock");
  endtask : t_lock

  task automatic t_status;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk) #1 fault = 8'(i);
      @(posedge clk) #1 chk("status_code", sc, 8'(i));
    end
    $display("done t_status");
  endtask : t_status

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    {rst_n, start_req, stop_req, mom, fault, link_b.valid, link_b.data} = '0;
    exp_cnt = 16'h0000;
    failures = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_master;
    t_lock;
    t_addr;
    t_status;
    t_reset;
    finish_test;
  end

  initial
  begin
    #2_000_000;
    failures++;
    finish_test;
  end
endmodule : tb
`default_nettype wire
